// File: fpd_core.sv
// Contract
// - Selector picks any status word for word 0
// - Return status, speed feedback, torque words
// - Six spy locations mirror last received words
// - Spy words are raw, unscaled
// - Out-of-limit values may be clamped
// - Failed word transfer flags a data error
// - Last code and count per direction
// - Refused source read reports code 200H
// - Hold select 1 substitutes fallbacks on loss
// - Hold select 0 freezes last valid values
// - All holders switch together, same cycle
// - Control fallback replaces all sixteen bits
// - Loss action: ignore, warn, trip; default warn
// - Control word bit n drives flag n
// - Two control words, own mapping and fallback
`timescale 1ns/1ps
module fpd_core #(
  parameter int NWORD = fpd_pkg::NWORD,
  parameter int NREF = fpd_pkg::NREF,
  parameter int NSRC = fpd_pkg::NSRC,
  parameter int CNT_W = fpd_pkg::CNT_W
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Protocol layer
  input wire logic link_healthy,
  input wire logic cfg_attempt,
  input wire logic rx_valid,
  input wire logic [NWORD*16-1:0] rx_words,
  input wire logic tx_req,
  output logic tx_valid,
  output logic [NWORD*16-1:0] tx_words,
  // Drive parameter space
  input wire logic [NSRC*16-1:0] drive_src,
  input wire logic [NSRC-1:0] drive_src_ok,
  output logic [15:0] ctrl_flags1,
  output logic [15:0] ctrl_flags2,
  output logic [NREF*16-1:0] refs,
  // Link-loss response and interrupt
  output logic link_warn,
  output logic link_trip,
  output logic irq
);

  // ==========================================================
  // Configuration registers
  logic hold_sel_ff;
  logic [1:0] loss_act_ff;
  logic clamp_en_ff;
  logic [NWORD*3-1:0] rx_map_ff;
  logic [NWORD*4-1:0] tx_map_ff;
  logic [31:0] cw_fb_ff;
  logic [NREF*16-1:0] ref_fb_ff;
  logic [fpd_pkg::INT_W-1:0] int_en_ff;
  logic [fpd_pkg::INT_W-1:0] int_stat_ff;
  logic [15:0] rx_code_ff;
  logic [CNT_W-1:0] rx_cnt_ff;
  logic [15:0] tx_code_ff;
  logic [CNT_W-1:0] tx_cnt_ff;
  logic link_prev_ff;

  // ==========================================================
  // APB handshake: one wait state, answer registered
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic apb_take;
  logic apb_wr;
  logic [31:0] nxt_prdata;
  logic nxt_pslverr;
  logic [NWORD*16-1:0] spy_flat;

  assign apb_take = psel && penable && pready_ff;
  assign apb_wr = apb_take && pwrite;

  always_comb
  begin
    nxt_prdata = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    case (paddr)
      fpd_pkg::OFS_CTRL:
      begin
        nxt_prdata[fpd_pkg::CTRL_HOLD_BIT] = hold_sel_ff;
        nxt_prdata[fpd_pkg::CTRL_ACT_LSB +: 2] = loss_act_ff;
        nxt_prdata[fpd_pkg::CTRL_CLAMP_BIT] = clamp_en_ff;
      end
      fpd_pkg::OFS_RX_MAP: nxt_prdata[NWORD*3-1:0] = rx_map_ff;
      fpd_pkg::OFS_TX_MAP: nxt_prdata[NWORD*4-1:0] = tx_map_ff;
      fpd_pkg::OFS_CW_FB: nxt_prdata = cw_fb_ff;
      fpd_pkg::OFS_REF_FB01: nxt_prdata = ref_fb_ff[31:0];
      fpd_pkg::OFS_REF_FB23: nxt_prdata = ref_fb_ff[63:32];
      fpd_pkg::OFS_RX_ERR: nxt_prdata = {rx_cnt_ff, rx_code_ff};
      fpd_pkg::OFS_TX_ERR: nxt_prdata = {tx_cnt_ff, tx_code_ff};
      fpd_pkg::OFS_INT_STAT: nxt_prdata[fpd_pkg::INT_W-1:0] = int_stat_ff;
      fpd_pkg::OFS_INT_CLR: nxt_prdata = 32'h0000_0000;
      fpd_pkg::OFS_INT_EN: nxt_prdata[fpd_pkg::INT_W-1:0] = int_en_ff;
      fpd_pkg::OFS_STATUS:
      begin
        nxt_prdata[fpd_pkg::STS_LINK_BIT] = link_prev_ff;
        nxt_prdata[fpd_pkg::STS_WARN_BIT] = link_warn;
        nxt_prdata[fpd_pkg::STS_TRIP_BIT] = link_trip;
      end
      default:
      begin
        if (paddr >= fpd_pkg::OFS_SPY0 && paddr <= fpd_pkg::OFS_SPY5 && paddr[1:0] == 2'h0)
          nxt_prdata[15:0] = spy_flat[16*((paddr - fpd_pkg::OFS_SPY0) >> 2) +: 16];
        else
          nxt_pslverr = 1'b1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end
    else
    begin
      pready_ff <= psel && penable && !pready_ff;
      if (psel && penable && !pready_ff)
      begin
        prdata_ff <= pwrite ? 32'h0000_0000 : nxt_prdata;
        pslverr_ff <= nxt_pslverr;
      end
      else
        pslverr_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Software-written configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_sel_ff <= fpd_pkg::RST_HOLD_SEL;
      loss_act_ff <= fpd_pkg::RST_LOSS_ACT;
      clamp_en_ff <= fpd_pkg::RST_CLAMP_EN;
      rx_map_ff <= fpd_pkg::RST_RX_MAP;
      tx_map_ff <= fpd_pkg::RST_TX_MAP;
      cw_fb_ff <= fpd_pkg::RST_CW_FB;
      ref_fb_ff <= fpd_pkg::RST_REF_FB;
      int_en_ff <= '0;
    end
    else if (apb_wr)
    begin
      case (paddr)
        fpd_pkg::OFS_CTRL:
        begin
          hold_sel_ff <= pwdata[fpd_pkg::CTRL_HOLD_BIT];
          loss_act_ff <= pwdata[fpd_pkg::CTRL_ACT_LSB +: 2];
          clamp_en_ff <= pwdata[fpd_pkg::CTRL_CLAMP_BIT];
        end
        fpd_pkg::OFS_RX_MAP: rx_map_ff <= pwdata[NWORD*3-1:0];
        fpd_pkg::OFS_TX_MAP: tx_map_ff <= pwdata[NWORD*4-1:0];
        fpd_pkg::OFS_CW_FB: cw_fb_ff <= pwdata;
        fpd_pkg::OFS_REF_FB01: ref_fb_ff[31:0] <= pwdata;
        fpd_pkg::OFS_REF_FB23: ref_fb_ff[63:32] <= pwdata;
        fpd_pkg::OFS_INT_EN: int_en_ff <= pwdata[fpd_pkg::INT_W-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Receive slots
  fpd_slot_if sif [NWORD] ();
  logic rx_load;
  logic [NWORD-1:0] slot_err;
  logic [NWORD*16-1:0] slot_code;
  logic [NWORD-1:0] slot_wr;
  logic [NWORD*3-1:0] slot_dest;
  logic [NWORD*16-1:0] slot_val;

  // Packets arriving on an unhealthy link are ignored
  assign rx_load = rx_valid && link_healthy;

  for (genvar g = 0; g < NWORD; g++)
  begin : g_slot
    assign sif[g].word = rx_words[16*g +: 16];
    assign sif[g].load = rx_load;
    assign sif[g].dest = rx_map_ff[3*g +: 3];
    assign sif[g].clamp_en = clamp_en_ff;
    assign spy_flat[16*g +: 16] = sif[g].spy;
    assign slot_err[g] = sif[g].err;
    assign slot_code[16*g +: 16] = sif[g].err_code;
    assign slot_wr[g] = sif[g].wr_en;
    assign slot_dest[3*g +: 3] = sif[g].wr_dest;
    assign slot_val[16*g +: 16] = sif[g].wr_val;
    fpd_rx_slot u_slot (
      .pclk(pclk),
      .presetn(presetn),
      .sif(sif[g])
    );
  end

  // ==========================================================
  // Holders: take slot writes only while the link is healthy
  logic [15:0] cw1_hold_ff;
  logic [15:0] cw2_hold_ff;
  logic [NREF*16-1:0] ref_hold_ff;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cw1_hold_ff <= 16'h0000;
      cw2_hold_ff <= 16'h0000;
      ref_hold_ff <= '0;
    end
    else if (link_healthy)
    begin
      for (int i = 0; i < NWORD; i++)
      begin
        if (slot_wr[i])
        begin
          if (slot_dest[3*i +: 3] == fpd_pkg::DST_CW1)
            cw1_hold_ff <= slot_val[16*i +: 16];
          else if (slot_dest[3*i +: 3] == fpd_pkg::DST_CW2)
            cw2_hold_ff <= slot_val[16*i +: 16];
          else
            ref_hold_ff[16*(slot_dest[3*i +: 3] - fpd_pkg::DST_REF0) +: 16]
              <= slot_val[16*i +: 16];
        end
      end
    end
  end

  // ==========================================================
  // Drive-facing outputs: freeze or fallback, one shared select
  logic use_fb;
  assign use_fb = !link_healthy && hold_sel_ff;

  logic [15:0] cw1_out_ff;
  logic [15:0] cw2_out_ff;
  logic [NREF*16-1:0] ref_out_ff;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cw1_out_ff <= 16'h0000;
      cw2_out_ff <= 16'h0000;
      ref_out_ff <= '0;
    end
    else
    begin
      // Every holder uses the same select, so none lags the others
      cw1_out_ff <= use_fb ? cw_fb_ff[15:0] : cw1_hold_ff;
      cw2_out_ff <= use_fb ? cw_fb_ff[31:16] : cw2_hold_ff;
      ref_out_ff <= use_fb ? ref_fb_ff : ref_hold_ff;
    end
  end
  assign ctrl_flags1 = cw1_out_ff;
  assign ctrl_flags2 = cw2_out_ff;
  assign refs = ref_out_ff;

  // ==========================================================
  // Transmit words
  logic tx_valid_ff;
  logic [NWORD*16-1:0] tx_words_ff;
  logic [NWORD*16-1:0] nxt_tx_words;
  logic [NWORD-1:0] tx_err_vec;
  always_comb
  begin
    logic [3:0] sel;
    logic [2:0] idx;
    sel = 4'h0;
    idx = 3'h0;
    nxt_tx_words = '0;
    tx_err_vec = '0;
    for (int i = 0; i < NWORD; i++)
    begin
      sel = tx_map_ff[4*i +: 4];
      idx = 3'(sel - 4'h1);
      if (sel == 4'h0)
        nxt_tx_words[16*i +: 16] = 16'h0000;
      else if (sel > 4'(NSRC) || !drive_src_ok[idx])
        tx_err_vec[i] = 1'b1;
      else
        nxt_tx_words[16*i +: 16] = drive_src[16*idx +: 16];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_valid_ff <= 1'b0;
      tx_words_ff <= '0;
    end
    else
    begin
      tx_valid_ff <= tx_req;
      if (tx_req)
        tx_words_ff <= nxt_tx_words;
    end
  end
  assign tx_valid = tx_valid_ff;
  assign tx_words = tx_words_ff;

  // ==========================================================
  // Data error records, saturating counters
  logic [3:0] rx_nerr;
  logic [3:0] tx_nerr;
  logic [15:0] rx_last;
  logic [CNT_W:0] rx_sum;
  logic [CNT_W:0] tx_sum;
  always_comb
  begin
    rx_nerr = 4'h0;
    tx_nerr = 4'h0;
    rx_last = rx_code_ff;
    for (int i = 0; i < NWORD; i++)
    begin
      rx_nerr = rx_nerr + 4'(slot_err[i]);
      tx_nerr = tx_nerr + 4'(tx_err_vec[i] & tx_req);
      if (slot_err[i])
        rx_last = slot_code[16*i +: 16];
    end
    rx_sum = {1'b0, rx_cnt_ff} + (CNT_W+1)'(rx_nerr);
    tx_sum = {1'b0, tx_cnt_ff} + (CNT_W+1)'(tx_nerr);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_code_ff <= 16'h0000;
      rx_cnt_ff <= '0;
      tx_code_ff <= 16'h0000;
      tx_cnt_ff <= '0;
    end
    else if (cfg_attempt)
    begin
      rx_cnt_ff <= '0;
      tx_cnt_ff <= '0;
    end
    else
    begin
      if (rx_nerr != 4'h0)
      begin
        rx_code_ff <= rx_last;
        rx_cnt_ff <= rx_sum[CNT_W] ? '1 : rx_sum[CNT_W-1:0];
      end
      if (tx_nerr != 4'h0)
      begin
        tx_code_ff <= fpd_pkg::ERR_READ_DENIED;
        tx_cnt_ff <= tx_sum[CNT_W] ? '1 : tx_sum[CNT_W-1:0];
      end
    end
  end

  // ==========================================================
  // Link-loss action
  logic link_lost;
  logic warn_ff;
  logic trip_ff;
  assign link_lost = link_prev_ff && !link_healthy;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link_prev_ff <= 1'b0;
      warn_ff <= 1'b0;
      trip_ff <= 1'b0;
    end
    else
    begin
      link_prev_ff <= link_healthy;
      // Warning follows the link level, so a late change of action still counts
      warn_ff <= !link_healthy && (loss_act_ff == fpd_pkg::ACT_WARN);
      // Trip latches until the next configuration attempt
      if (link_lost && loss_act_ff == fpd_pkg::ACT_TRIP)
        trip_ff <= 1'b1;
      else if (cfg_attempt)
        trip_ff <= 1'b0;
    end
  end
  assign link_warn = warn_ff;
  assign link_trip = trip_ff;

  // ==========================================================
  // Interrupts: set beats a clear in the same cycle
  logic [fpd_pkg::INT_W-1:0] int_set;
  logic [fpd_pkg::INT_W-1:0] int_clr;
  logic irq_ff;
  always_comb
  begin
    int_set = '0;
    int_set[fpd_pkg::INT_RX_ERR] = rx_nerr != 4'h0;
    int_set[fpd_pkg::INT_TX_ERR] = tx_nerr != 4'h0;
    int_set[fpd_pkg::INT_LINK_LOST] = link_lost;
    int_clr = '0;
    if (apb_wr && paddr == fpd_pkg::OFS_INT_CLR)
      int_clr = pwdata[fpd_pkg::INT_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_stat_ff <= '0;
      irq_ff <= 1'b0;
    end
    else
    begin
      int_stat_ff <= (int_stat_ff & ~int_clr) | int_set;
      irq_ff <= |(((int_stat_ff & ~int_clr) | int_set) & int_en_ff);
    end
  end
  assign irq = irq_ff;

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

endmodule

// File: fpd_dp_master.sv
`timescale 1ns/1ps
// ========
// Cyclic process data master
module fpd_dp_master (
  // Clock
  input wire logic pclk,
  // Process data
  output logic rx_valid,
  output logic [95:0] rx_words,
  output logic link_healthy,
  output logic tx_req,
  input wire logic tx_valid,
  input wire logic [95:0] tx_words
);
  initial
  begin
    rx_valid = 1'b0;
    rx_words = 96'h0;
    link_healthy = 1'b1;
    tx_req = 1'b0;
  end
  // Word 0 run/stop, word 1 speed with 5000 at half speed
  task automatic send(input logic [95:0] pk);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_words <= pk;
    @(posedge pclk);
    rx_valid <= 1'b0;
    // Idle words are garbage, never the last packet
    rx_words <= ~pk;
  endtask
  task automatic link(input logic h);
    @(posedge pclk);
    link_healthy <= h;
  endtask
  task automatic poll(output logic v, output logic [95:0] t);
    @(posedge pclk);
    tx_req <= 1'b1;
    @(posedge pclk);
    tx_req <= 1'b0;
    @(posedge pclk);
    v = tx_valid;
    t = tx_words;
  endtask
endmodule

// File: fpd_pkg.sv
package fpd_pkg;

  // ==========================================================
  // Sizes
  localparam int NWORD = 6;
  localparam int NREF = 4;
  localparam int NSRC = 8;
  localparam int WORD_W = 16;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;

  // ==========================================================
  // Receive destinations, one 3-bit field per received word
  localparam int DST_W = 3;
  localparam logic [2:0] DST_NONE = 3'h0;
  localparam logic [2:0] DST_CW1 = 3'h1;
  localparam logic [2:0] DST_CW2 = 3'h2;
  localparam logic [2:0] DST_REF0 = 3'h3;
  localparam logic [2:0] DST_REF3 = 3'h6;

  // Transmit source select, 4 bits per word, 0 sends zero
  localparam int TXSEL_W = 4;

  // Reference holder limits, 100.00 % = 10000
  localparam logic signed [15:0] REF_MAX = 16'sh2710;
  localparam logic signed [15:0] REF_MIN = -16'sh2710;

  // ==========================================================
  // Data error codes
  localparam logic [15:0] ERR_WRITE_DENIED = 16'h0100;
  localparam logic [15:0] ERR_READ_DENIED = 16'h0200;
  localparam logic [15:0] ERR_RANGE = 16'h0300;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RX_MAP = 8'h04;
  localparam logic [7:0] OFS_TX_MAP = 8'h08;
  localparam logic [7:0] OFS_CW_FB = 8'h0c;
  localparam logic [7:0] OFS_REF_FB01 = 8'h10;
  localparam logic [7:0] OFS_REF_FB23 = 8'h14;
  localparam logic [7:0] OFS_RX_ERR = 8'h18;
  localparam logic [7:0] OFS_TX_ERR = 8'h1c;
  localparam logic [7:0] OFS_INT_STAT = 8'h20;
  localparam logic [7:0] OFS_INT_CLR = 8'h24;
  localparam logic [7:0] OFS_INT_EN = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2c;
  localparam logic [7:0] OFS_SPY0 = 8'h30;
  localparam logic [7:0] OFS_SPY5 = 8'h44;

  // CTRL fields
  localparam int CTRL_HOLD_BIT = 0;
  localparam int CTRL_ACT_LSB = 1;
  localparam int CTRL_CLAMP_BIT = 3;
  localparam logic [1:0] ACT_IGNORE = 2'h0;
  localparam logic [1:0] ACT_WARN = 2'h1;
  localparam logic [1:0] ACT_TRIP = 2'h2;

  // Interrupt bits
  localparam int INT_W = 3;
  localparam int INT_RX_ERR = 0;
  localparam int INT_TX_ERR = 1;
  localparam int INT_LINK_LOST = 2;

  // STATUS fields
  localparam int STS_LINK_BIT = 0;
  localparam int STS_WARN_BIT = 1;
  localparam int STS_TRIP_BIT = 2;

  // Reset values
  localparam logic RST_HOLD_SEL = 1'b0;
  localparam logic [1:0] RST_LOSS_ACT = ACT_WARN;
  localparam logic RST_CLAMP_EN = 1'b1;
  localparam logic [17:0] RST_RX_MAP = 18'h00000;
  localparam logic [23:0] RST_TX_MAP = 24'h000651;
  localparam logic [31:0] RST_CW_FB = 32'h0000_0000;
  localparam logic [63:0] RST_REF_FB = 64'h0;

endpackage

// File: fpd_rx_slot.sv
`timescale 1ns/1ps
module fpd_rx_slot (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Core side
  fpd_slot_if.slot sif
);

  logic is_ref;
  logic signed [15:0] sval;
  logic over;
  logic under;

  assign is_ref = (sif.dest >= fpd_pkg::DST_REF0) && (sif.dest <= fpd_pkg::DST_REF3);
  assign sval = sif.word;
  assign over = sval > fpd_pkg::REF_MAX;
  assign under = sval < fpd_pkg::REF_MIN;

  // ==========================================================
  // Spy copy, raw and unscaled
  logic [15:0] spy_ff;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      spy_ff <= 16'h0000;
    else if (sif.load)
      spy_ff <= sif.word;
  end
  assign sif.spy = spy_ff;

  // ==========================================================
  // Write request towards the holders, one cycle after load
  logic wr_en_ff;
  logic [2:0] wr_dest_ff;
  logic [15:0] wr_val_ff;
  logic err_ff;
  logic [15:0] err_code_ff;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_en_ff <= 1'b0;
      wr_dest_ff <= fpd_pkg::DST_NONE;
      wr_val_ff <= 16'h0000;
      err_ff <= 1'b0;
      err_code_ff <= 16'h0000;
    end
    else
    begin
      wr_en_ff <= 1'b0;
      err_ff <= 1'b0;
      wr_dest_ff <= sif.dest;
      wr_val_ff <= sif.word;
      if (sif.load && sif.dest != fpd_pkg::DST_NONE)
      begin
        if (sif.dest == fpd_pkg::DST_CW1 || sif.dest == fpd_pkg::DST_CW2)
          wr_en_ff <= 1'b1;
        else if (!is_ref)
        begin
          err_ff <= 1'b1;
          err_code_ff <= fpd_pkg::ERR_WRITE_DENIED;
        end
        else if (over || under)
        begin
          if (sif.clamp_en)
          begin
            wr_en_ff <= 1'b1;
            wr_val_ff <= over ? fpd_pkg::REF_MAX : fpd_pkg::REF_MIN;
          end
          else
          begin
            err_ff <= 1'b1;
            err_code_ff <= fpd_pkg::ERR_RANGE;
          end
        end
        else
          wr_en_ff <= 1'b1;
      end
    end
  end

  assign sif.wr_en = wr_en_ff;
  assign sif.wr_dest = wr_dest_ff;
  assign sif.wr_val = wr_val_ff;
  assign sif.err = err_ff;
  assign sif.err_code = err_code_ff;

endmodule

// File: fpd_slot_if.sv
`timescale 1ns/1ps
interface fpd_slot_if;
  logic [15:0] word;
  logic load;
  logic [2:0] dest;
  logic clamp_en;
  logic [15:0] spy;
  logic wr_en;
  logic [2:0] wr_dest;
  logic [15:0] wr_val;
  logic err;
  logic [15:0] err_code;

  modport core (output word, load, dest, clamp_en,
                input spy, wr_en, wr_dest, wr_val, err, err_code);
  modport slot (input word, load, dest, clamp_en,
                output spy, wr_en, wr_dest, wr_val, err, err_code);
endinterface

// File: fpd_sva.sv
`timescale 1ns/1ps
// ========
// Checker
module fpd_sva #(
  parameter int NWORD = fpd_pkg::NWORD,
  parameter int NREF = fpd_pkg::NREF
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus and link
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic link_healthy,
  input wire logic cfg_attempt,
  input wire logic tx_req,
  input wire logic tx_valid,
  input wire logic [NWORD*16-1:0] tx_words,
  // Drive side
  input wire logic [15:0] ctrl_flags1,
  input wire logic [NREF*16-1:0] refs,
  input wire logic link_warn,
  input wire logic link_trip
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_tx_answer: assert property (tx_req |=> tx_valid)
    else $error("tx_valid missing");
  a_tx_hold: assert property (!tx_req |=> $stable(tx_words) && !tx_valid)
    else $error("tx words moved");
  a_warn_healthy: assert property (link_healthy |=> !link_warn)
    else $error("warn without loss");
  a_trip_latch: assert property (link_trip && !cfg_attempt |=> link_trip)
    else $error("trip dropped");
  a_trip_cause: assert property ($rose(link_trip) |-> $past(!link_healthy))
    else $error("trip without loss");
  a_cfg_clear: assert property (cfg_attempt && link_healthy |=> !link_trip)
    else $error("trip not cleared");
  // Fallback or freeze must settle within four cycles of loss, then stay put
  a_loss_steady: assert property ((!link_healthy && !psel) [*4] |=>
    $stable(refs) && $stable(ctrl_flags1))
    else $error("holders moved during loss");
endmodule

bind fpd_core fpd_sva #(.NWORD(NWORD), .NREF(NREF)) fpd_sva_i (.pclk, .presetn, .psel,
  .penable, .pready, .link_healthy, .cfg_attempt, .tx_req, .tx_valid, .tx_words,
  .ctrl_flags1, .refs, .link_warn, .link_trip);

// File: tb_top.sv
`timescale 1ns/1ps
// ========
// Testbench
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic link_healthy;
  logic cfg_attempt = 1'b0;
  logic rx_valid;
  logic [95:0] rx_words;
  logic tx_req;
  logic tx_valid;
  logic [95:0] tx_words;
  logic [127:0] drive_src = 128'h0;
  logic [7:0] drive_src_ok = 8'hff;
  logic [15:0] ctrl_flags1;
  logic [15:0] ctrl_flags2;
  logic [63:0] refs;
  logic link_warn;
  logic link_trip;
  logic irq;
  logic [31:0] seed = 32'h0000e021;
  int fail_count = 0;
  int compares = 0;

  always #5 pclk = ~pclk;

  fpd_core fpd_core_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .link_healthy, .cfg_attempt, .rx_valid, .rx_words,
    .tx_req, .tx_valid, .tx_words, .drive_src, .drive_src_ok, .ctrl_flags1,
    .ctrl_flags2, .refs, .link_warn, .link_trip, .irq);
  fpd_dp_master fpd_dp_master_i (.pclk, .rx_valid, .rx_words, .link_healthy,
    .tx_req, .tx_valid, .tx_words);

  // ========
  // Helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] clampf(input logic [15:0] v);
    if ($signed(v) > fpd_pkg::REF_MAX)
      return fpd_pkg::REF_MAX;
    if ($signed(v) < fpd_pkg::REF_MIN)
      return fpd_pkg::REF_MIN;
    return v;
  endfunction
  // Missing source word goes out as zero
  function automatic logic [95:0] txexp(input logic [7:0] ok);
    logic [95:0] t;
    logic [3:0] k;
    t = 96'h0;
    for (int i = 0; i < 6; i++)
    begin
      k = fpd_pkg::RST_TX_MAP[4*i+:4];
      if (k != 4'h0 && k <= 4'h8 && ok[k-4'h1])
        t[16*i+:16] = drive_src[16*(k-1)+:16];
    end
    return t;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait as long as the slave needs; the watchdog ends a hang
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
  endtask
  task automatic conclude();
    if (fail_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ========
  // Scenarios
  initial
  begin
    logic [95:0] p;
    logic [95:0] t;
    logic [95:0] x;
    logic [31:0] r;
    logic e;
    logic v;
    logic h;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(fpd_pkg::OFS_CTRL, 32'h0000000a);
    rdc(fpd_pkg::OFS_TX_MAP, 32'h00000651);
    apb(1'b0, 8'h48, 32'h0, r, e);
    chk(e, 1'b1);
    // Word 0 to cw1, 1 to ref0, 2 refused, 3 to ref3, 4 to ref1, 5 to cw2
    wr(fpd_pkg::OFS_RX_MAP, 32'h00014dd9);
    for (int k = 0; k < 3; k++)
    begin
      p = {xs(), xs(), xs()};
      fpd_dp_master_i.send(p);
    end
    repeat (4) @(posedge pclk);
    for (int i = 0; i < 6; i++)
      rdc(fpd_pkg::OFS_SPY0 + 8'(4 * i), {16'h0, p[16*i+:16]});
    chk(ctrl_flags1, p[15:0]);
    chk(ctrl_flags2, p[95:80]);
    chk(refs[15:0], clampf(p[31:16]));
    chk(refs[31:16], clampf(p[79:64]));
    chk(refs[47:32], 16'h0000);
    chk(refs[63:48], clampf(p[63:48]));
    rdc(fpd_pkg::OFS_RX_ERR, {16'h0003, fpd_pkg::ERR_WRITE_DENIED});
    wr(fpd_pkg::OFS_INT_EN, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    wr(fpd_pkg::OFS_INT_CLR, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    drive_src <= {xs(), xs(), xs(), xs()};
    for (int j = 0; j < 2; j++)
    begin
      drive_src_ok <= j ? 8'hfe : 8'hff;
      fpd_dp_master_i.poll(v, t);
      x = txexp(drive_src_ok);
      chk(v, 1'b1);
      for (int i = 0; i < 6; i++)
        chk(t[16*i+:16], x[16*i+:16]);
    end
    rdc(fpd_pkg::OFS_TX_ERR, {16'h0001, fpd_pkg::ERR_READ_DENIED});
    wr(fpd_pkg::OFS_CW_FB, 32'ha5a50000);
    wr(fpd_pkg::OFS_REF_FB01, 32'h00001388);
    for (int a = 0; a < 3; a++)
    begin
      h = (a == 2);
      wr(fpd_pkg::OFS_CTRL, {28'h0, 1'b1, 2'(a), h});
      p = {xs(), xs(), xs()};
      fpd_dp_master_i.send(p);
      repeat (4) @(posedge pclk);
      fpd_dp_master_i.link(1'b0);
      // Packets during loss must be ignored
      fpd_dp_master_i.send(~p);
      repeat (3) @(posedge pclk);
      chk(link_warn, a == 1);
      chk(link_trip, a == 2);
      chk(ctrl_flags1, h ? 16'h0000 : p[15:0]);
      chk(ctrl_flags2, h ? 16'ha5a5 : p[95:80]);
      chk(refs[15:0], h ? 16'h1388 : clampf(p[31:16]));
      chk(refs[31:16], h ? 16'h0000 : clampf(p[79:64]));
      chk(refs[63:48], h ? 16'h0000 : clampf(p[63:48]));
      rdc(fpd_pkg::OFS_STATUS, {29'h0, a == 2, a == 1, 1'b0});
      rdc(fpd_pkg::OFS_SPY0, {16'h0, p[15:0]});
      fpd_dp_master_i.link(1'b1);
      @(posedge pclk);
      cfg_attempt <= 1'b1;
      @(posedge pclk);
      cfg_attempt <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(link_trip, 1'b0);
      apb(1'b0, fpd_pkg::OFS_RX_ERR, 32'h0, r, e);
      chk(r[31:16], 16'h0);
    end
    // Clamp off: an out-of-limit reference is refused, the holder keeps its value
    wr(fpd_pkg::OFS_CTRL, 32'h00000002);
    wr(fpd_pkg::OFS_RX_MAP, 32'h00000018);
    fpd_dp_master_i.send({64'h0, 16'h8000, 16'h0000});
    repeat (4) @(posedge pclk);
    chk(refs[15:0], clampf(p[31:16]));
    rdc(fpd_pkg::OFS_RX_ERR, {16'h0001, fpd_pkg::ERR_RANGE});
    conclude();
  end

  initial
  begin
    #100000;
    fail_count++;
    conclude();
  end
endmodule
